// ===== verilog/alu_pkg.sv
// Purpose: shared constants for the complement and decimal adjust datapath
// Assumes: 8-bit data, single clock
// Notes: opcode codes are local to this block
`default_nettype none
package alu_pkg;
	localparam int unsigned DATA_W = 8; // data byte width
	localparam int unsigned NIB_W = 4; // nibble width
	localparam logic [3:0] NIB_MAX = 4'h9; // largest decimal digit
	localparam logic [3:0] NIB_FIX = 4'h6; // per-nibble correction
	localparam logic [7:0] FIX_NONE = 8'h00; // no correction
	localparam logic [7:0] FIX_LO = 8'h06; // low nibble correction
	localparam logic [7:0] FIX_HI = 8'h60; // high nibble correction
	localparam logic [7:0] FIX_BOTH = 8'h66; // both nibbles
	localparam logic [7:0] ACC_RST = 8'h00; // accumulator reset value
	localparam logic [7:0] ZERO_BYTE = 8'h00; // all-zero result
	localparam logic FLAG_RST = 1'b0; // flag reset value
	// operation select
	typedef enum logic [1:0] {
		OP_NONE = 2'b00,
		OP_INVERT_MEM_IN_PLACE = 2'b01,
		OP_INVERT_MEM_TO_ACC = 2'b10,
		OP_DECIMAL_ADJUST_TO_MEM = 2'b11
	} alu_op_t;
endpackage : alu_pkg
`default_nettype wire

// ===== verilog/decimal_fix.sv
// Purpose: compute the decimal adjust correction and resulting carry
// Assumes: input is the binary sum of two packed decimal bytes
// Notes: purely combinational
`default_nettype none
module decimal_fix (
	input wire logic [7:0] acc_i,
	input wire logic half_carry_i,
	input wire logic carry_i,
	output logic [7:0] result_o,
	output logic carry_o
);
	logic fix_lo; // low nibble needs correction
	logic fix_hi; // high nibble needs correction
	logic [7:0] fix; // selected constant
	logic [8:0] sum; // widened sum for carry out

	// choose one of four constants from nibble and flag state
	always_comb begin
		fix_lo = (acc_i[3:0] > alu_pkg::NIB_MAX) || half_carry_i; // see [RULE_03]
		fix_hi = (acc_i[7:4] > alu_pkg::NIB_MAX) || carry_i; // see [RULE_04]
		unique case ({fix_hi, fix_lo})
			2'b00: fix = alu_pkg::FIX_NONE; // see [RULE_05]
			2'b01: fix = alu_pkg::FIX_LO;
			2'b10: fix = alu_pkg::FIX_HI;
			2'b11: fix = alu_pkg::FIX_BOTH;
		endcase
		sum = {1'b0, acc_i} + {1'b0, fix};
		result_o = sum[7:0];
		// carry kept once set so multi-byte chains work; set on carry out of bit 7 of the corrected sum
		carry_o = carry_i | sum[8]; // see [RULE_06]
	end
endmodule : decimal_fix
`default_nettype wire

// ===== verilog/compl_bcd_alu.sv
// Purpose: datapath for in-place invert, invert to accumulator, decimal adjust
// Assumes: memory read data valid in the cycle op_valid_i is high
// Notes: one operation per cycle; flags and accumulator held locally
//
// Overview of operation
// [RULE_01] invert memory byte in place, zero flag only
// [RULE_02] inverted memory byte into accumulator, set zero
// [RULE_03] low nibble over 9 or half-carry: add 6
// [RULE_04] high nibble over 9 or carry: add 6
// [RULE_05] correction is 00H, 06H, 60H or 66H
// [RULE_06] decimal adjust changes only carry, sets on overflow
// [RULE_07] decimal adjust writes result to memory only
// [RULE_08] zero flag set when result byte is zero
`default_nettype none
module compl_bcd_alu (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic op_valid_i,
	input wire logic [1:0] op_sel_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic acc_load_i,
	input wire logic [7:0] acc_load_data_i,
	input wire logic flags_load_i,
	input wire logic carry_load_i,
	input wire logic half_carry_load_i,
	input wire logic zero_load_i,
	output logic mem_we_o,
	output logic [7:0] mem_wdata_o,
	output logic [7:0] accumulator_o,
	output logic carry_flag_o,
	output logic half_carry_flag_o,
	output logic zero_flag_o
);
	alu_pkg::alu_op_t op; // decoded operation
	logic [7:0] inv; // inverted memory byte
	logic [7:0] dec_res; // adjusted byte
	logic dec_carry; // adjusted carry
	logic [7:0] acc_q, acc_d; // accumulator
	logic c_q, c_d; // carry flag
	logic ac_q, ac_d; // half carry flag
	logic z_q, z_d; // zero flag
	logic we_q, we_d; // memory write strobe
	logic [7:0] wd_q, wd_d; // memory write data

	assign op = alu_pkg::alu_op_t'(op_sel_i);
	assign inv = ~mem_rdata_i;

	// correction adder
	decimal_fix u_fix (
		.acc_i(acc_q),
		.half_carry_i(ac_q),
		.carry_i(c_q),
		.result_o(dec_res),
		.carry_o(dec_carry)
	);

	// next-state for accumulator, flags and memory write
	always_comb begin
		acc_d = acc_q;
		c_d = c_q;
		ac_d = ac_q;
		z_d = z_q;
		we_d = 1'b0;
		wd_d = wd_q;
		// outside load from the rest of the core (other instructions)
		if (acc_load_i) begin
			acc_d = acc_load_data_i;
		end
		if (flags_load_i) begin
			c_d = carry_load_i;
			ac_d = half_carry_load_i;
			z_d = zero_load_i;
		end
		if (op_valid_i) begin
			unique case (op)
				alu_pkg::OP_NONE: begin
				end
				alu_pkg::OP_INVERT_MEM_IN_PLACE: begin
					we_d = 1'b1; // see [RULE_01]
					wd_d = inv;
					z_d = (inv == alu_pkg::ZERO_BYTE); // see [RULE_08]
				end
				alu_pkg::OP_INVERT_MEM_TO_ACC: begin
					acc_d = inv; // see [RULE_02]
					z_d = (inv == alu_pkg::ZERO_BYTE); // see [RULE_08]
				end
				alu_pkg::OP_DECIMAL_ADJUST_TO_MEM: begin
					we_d = 1'b1; // see [RULE_07]
					wd_d = dec_res;
					c_d = dec_carry; // see [RULE_06]
				end
			endcase
		end
	end

	// register state
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			acc_q <= alu_pkg::ACC_RST;
			c_q <= alu_pkg::FLAG_RST;
			ac_q <= alu_pkg::FLAG_RST;
			z_q <= alu_pkg::FLAG_RST;
			we_q <= 1'b0;
			wd_q <= alu_pkg::ZERO_BYTE;
		end else begin
			acc_q <= acc_d;
			c_q <= c_d;
			ac_q <= ac_d;
			z_q <= z_d;
			we_q <= we_d;
			wd_q <= wd_d;
		end
	end

	assign mem_we_o = we_q;
	assign mem_wdata_o = wd_q;
	assign accumulator_o = acc_q;
	assign carry_flag_o = c_q;
	assign half_carry_flag_o = ac_q;
	assign zero_flag_o = z_q;
endmodule : compl_bcd_alu
`default_nettype wire

// ===== tb/compl_bcd_alu_chk.sv
// Purpose: port checks for compl_bcd_alu
// Assumes: one clock, sync reset
// Notes: bind follows the module
`default_nettype none
module compl_bcd_alu_chk (
	input wire logic clk_sys_i,
	input wire logic sys_rst_i,
	input wire logic op_valid_i,
	input wire logic acc_load_i,
	input wire logic flags_load_i,
	input wire logic mem_we_o,
	input wire logic carry_flag_o,
	input wire logic half_carry_flag_o,
	input wire logic zero_flag_o,
	input wire logic [1:0] op_sel_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic [7:0] mem_wdata_o,
	input wire logic [7:0] accumulator_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (sys_rst_i);
	wire c1 = op_valid_i && op_sel_i == 2'h1; // in-place invert
	wire c2 = op_valid_i && op_sel_i == 2'h2; // invert to accumulator
	// adjusted sum, carry out in bit 8
	wire [8:0] s = {1'h0, accumulator_o} + {1'h0, accumulator_o[7:4] > 4'h9 || carry_flag_o ?
		4'h6 : 4'h0, accumulator_o[3:0] > 4'h9 || half_carry_flag_o ? 4'h6 : 4'h0};
	sequence adj_s; op_valid_i && op_sel_i == 2'h3; endsequence
	inv_mem_a:
		assert property (c1 |=> mem_we_o && mem_wdata_o == ~$past(mem_rdata_i))
		else $error("bad invert");
	inv_zero_a:
		assert property (c1 |=> zero_flag_o == (mem_wdata_o == 8'h00))
		else $error("bad zero");
	inv_keep_a:
		assert property (c1 && !flags_load_i |=> $stable({carry_flag_o, half_carry_flag_o}))
		else $error("flag moved");
	to_acc_a:
		assert property (c2 |=> !mem_we_o && accumulator_o == ~$past(mem_rdata_i))
		else $error("bad acc");
	adj_sum_a:
		assert property (adj_s |=> mem_we_o && mem_wdata_o == $past(s[7:0]))
		else $error("bad adjust");
	adj_carry_a:
		assert property (adj_s |=> carry_flag_o == ($past(s[8]) | $past(carry_flag_o)))
		else $error("bad carry");
	adj_keep_a:
		assert property (adj_s ##0 !flags_load_i && !acc_load_i |=>
			$stable({zero_flag_o, half_carry_flag_o, accumulator_o}))
		else $error("state moved");
	no_write_a:
		assert property (!op_valid_i || !op_sel_i[0] |=> !mem_we_o)
		else $error("stray write");
endmodule : compl_bcd_alu_chk
bind compl_bcd_alu compl_bcd_alu_chk u_chk (.*);
`default_nettype wire

// ===== tb/compl_bcd_alu_test.sv
// Purpose: self-checking bench for compl_bcd_alu
// Assumes: 40 MHz clock, inputs set 2 ns after the edge
// Notes: driver queues notes, monitor compares
`default_nettype none
module compl_bcd_alu_test;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys_i = 1'h0, sys_rst_i = 1'h1, op_valid_i, acc_load_i, flags_load_i, c, ac, z;
	logic carry_load_i, half_carry_load_i, zero_load_i, mem_we_o, carry_flag_o;
	logic half_carry_flag_o, zero_flag_o;
	logic [1:0] op_sel_i;
	logic [7:0] mem_rdata_i, acc_load_data_i, mem_wdata_o, accumulator_o, wd, acc; // wd, acc: model
	logic [8:0] s;
	logic [19:0] q[$]; // notes: we, data, acc, c, ac, z
	integer seed = 32'hDF1A;
	int n_mismatch = 0, tests_run = 0, cyc = 0;
	wire [19:0] got = {mem_we_o, mem_wdata_o, accumulator_o, carry_flag_o, half_carry_flag_o,
		zero_flag_o};
	always #12.5 clk_sys_i = ~clk_sys_i;
	compl_bcd_alu u_compl_bcd_alu (.*);
	// drive one cycle, step the model, queue the note
	task automatic step(input logic [23:0] x);
		if (x[23]) x[12:11] = 2'h0; // no load beside an op
		{op_valid_i, op_sel_i, mem_rdata_i, acc_load_i, flags_load_i, acc_load_data_i,
			carry_load_i, half_carry_load_i, zero_load_i} = x;
		if (acc_load_i) acc = acc_load_data_i;
		if (flags_load_i) {c, ac, z} = {carry_load_i, half_carry_load_i, zero_load_i};
		s = {1'h0, acc} + {1'h0, acc[7:4] > 4'h9 || c ? 4'h6 : 4'h0, acc[3:0] > 4'h9 || ac ?
			4'h6 : 4'h0};
		case (op_valid_i ? op_sel_i : 2'h0)
			2'h1: {wd, z} = {~mem_rdata_i, mem_rdata_i == 8'hFF};
			2'h2: {acc, z} = {~mem_rdata_i, mem_rdata_i == 8'hFF};
			2'h3: {wd, c} = {s[7:0], c | s[8]};
			default: ;
		endcase
		q.push_back({op_valid_i & op_sel_i[0], wd, acc, c, ac, z});
	endtask : step
	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : finish_test
	// monitor: cycle limit, then oldest note against settled outputs
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc > 1000) begin
			n_mismatch++;
			finish_test;
		end
		#1;
		if (q.size() > 0) begin
			tests_run++;
			if (got !== q[0]) begin
				n_mismatch++;
				$display("wrong value at %0t got %h exp %h", $time, got, q[0]);
			end
			q.delete(0);
		end
	end
	initial begin
		{wd, acc, c, ac, z} = 19'h0;
		step(24'h0); // reset values all zero
		repeat (10) @(posedge clk_sys_i);
		#2 sys_rst_i = 1'h0;
		@(posedge clk_sys_i) #2 step(24'hBFE000);
		@(posedge clk_sys_i) #2 step(24'hDFE000);
		$display("test directed done");
		repeat (600) @(posedge clk_sys_i) #2 step(24'($random(seed)));
		@(posedge clk_sys_i) #2 step(24'h0);
		$display("test random done");
		@(posedge clk_sys_i) #3 finish_test;
	end
endmodule : compl_bcd_alu_test
`default_nettype wire
